// ---- logic/gptm_timer.sv ----
// general-purpose 16-bit reload timer: one-shot, triggered one-shot, continuous
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "gptm_consts.svh"
module gptm_timer (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        trigIn,
	output logic             timerOut,
	output logic             timerOutAf,
	output logic             timerIrq
);

	gptm_pkg::gptm_ctrl_s  ctrl_r;
	gptm_pkg::gptm_state_e state_r;
	gptm_pkg::gptm_state_e state_nxt;
	logic [15:0]           cnt_r;
	logic [15:0]           reload_r;
	logic [31:0]           prdata_r;
	logic                  lvl_r;
	logic                  irq_r;
	logic                  trigMeta_r;
	logic                  trigSync_r;
	logic                  trigDly_r;
	logic                  trigEdge;
	logic                  tick;
	logic                  hit;
	logic                  run;
	logic                  apbWr;
	logic                  wrCtrl;
	logic                  wrCount;
	logic                  wrReload;
	logic                  oneShotKind;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	function automatic logic isMapped(input logic [11:0] addr);
		return (addr == `GPTM_OFF_CTRL) || (addr == `GPTM_OFF_COUNT) ||
			(addr == `GPTM_OFF_RELOAD) || (addr == `GPTM_OFF_STATUS);
	endfunction

	// zero wait states: read data is latched in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !isMapped(paddr);
	assign prdata   = prdata_r;
	assign apbWr    = psel && penable && pwrite;
	assign wrCtrl   = apbWr && (paddr == `GPTM_OFF_CTRL);
	assign wrCount  = apbWr && (paddr == `GPTM_OFF_COUNT);
	assign wrReload = apbWr && (paddr == `GPTM_OFF_RELOAD);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`GPTM_OFF_CTRL:   prdata_r <= {24'h000000, ctrl_r};
				`GPTM_OFF_COUNT:  prdata_r <= {16'h0000, cnt_r};
				`GPTM_OFF_RELOAD: prdata_r <= {16'h0000, reload_r};
				`GPTM_OFF_STATUS: prdata_r <= {30'h00000000, state_r};
				default:          prdata_r <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// control and reload registers
	// ------------------------------------------------------------
	assign oneShotKind = (ctrl_r.mode != gptm_pkg::MODE_CONT);

	// a software write wins over the self-clear at single-shot time-out
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_r <= gptm_pkg::gptm_ctrl_s'(`GPTM_RST_CTRL);
		end else if (wrCtrl) begin
			ctrl_r <= gptm_pkg::gptm_ctrl_s'(pwdata[7:0]);
		end else if (hit && ctrl_r.mode != gptm_pkg::MODE_TRIGGER && oneShotKind) begin
			ctrl_r.en <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reload_r <= `GPTM_RST_RELOAD;
		end else if (wrReload) begin
			reload_r <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// trigger input synchroniser and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			trigMeta_r <= 1'b0;
			trigSync_r <= 1'b0;
			trigDly_r  <= 1'b0;
		end else begin
			trigMeta_r <= trigIn;
			trigSync_r <= trigMeta_r;
			trigDly_r  <= trigSync_r;
		end
	end

	// polarity low selects the rising edge, high the falling edge
	assign trigEdge = ctrl_r.inputOutputPolaritySelect ? (trigDly_r && !trigSync_r) :
		(trigSync_r && !trigDly_r);

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			gptm_pkg::ST_STOP: begin
				if (ctrl_r.en && ctrl_r.mode == gptm_pkg::MODE_TRIGGER) begin
					state_nxt = gptm_pkg::ST_ARMED;
				end else if (ctrl_r.en) begin
					state_nxt = gptm_pkg::ST_RUN;
				end
			end
			gptm_pkg::ST_ARMED: begin
				if (!ctrl_r.en) begin
					state_nxt = gptm_pkg::ST_STOP;
				end else if (trigEdge) begin
					state_nxt = gptm_pkg::ST_RUN;
				end
			end
			gptm_pkg::ST_RUN: begin
				if (!ctrl_r.en) begin
					state_nxt = gptm_pkg::ST_STOP;
				end else if (hit && ctrl_r.mode == gptm_pkg::MODE_TRIGGER) begin
					state_nxt = gptm_pkg::ST_ARMED;
				end else if (hit && oneShotKind) begin
					state_nxt = gptm_pkg::ST_STOP;
				end
			end
			default: state_nxt = gptm_pkg::ST_STOP;
		endcase
	end

	// edges seen in RUN are not remembered, so they cannot restart the run
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= gptm_pkg::ST_STOP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// gated by the enable bit so that clearing it stops the very next tick
	assign run = (state_r == gptm_pkg::ST_RUN) && ctrl_r.en;

	gptm_prescaler u_prescaler (
		.clk   (clk),
		.nrst  (nrst),
		.run   (run),
		.psSel (ctrl_r.psSel),
		.tick  (tick)
	);

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	// one prescaled tick per count, so time-out = (reload - start + 1) x prescale
	assign hit = tick && (cnt_r == reload_r);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_r <= `GPTM_RST_COUNT;
		end else if (wrCount) begin
			cnt_r <= pwdata[15:0];
		end else if (hit) begin
			cnt_r <= `GPTM_COUNT_START;
		end else if (tick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// output level and interrupt request
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lvl_r <= 1'b0;
		end else if (oneShotKind) begin
			lvl_r <= hit ? !ctrl_r.inputOutputPolaritySelect :
				ctrl_r.inputOutputPolaritySelect;
		end else if (!run) begin
			lvl_r <= ctrl_r.inputOutputPolaritySelect;
		end else if (hit) begin
			lvl_r <= !lvl_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= hit;
		end
	end

	assign timerOut   = lvl_r;
	assign timerOutAf = ctrl_r.outAf;
	assign timerIrq   = irq_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	AST_RELOAD_TO_ONE: assert property (hit && !wrCount |=> cnt_r == 16'h0001)
		else $error("counter did not return to one after reload");
	AST_INCREMENT: assert property (tick && !hit && !wrCount |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not step by one on a tick");
	AST_WRAP: assert property (tick && cnt_r == 16'hFFFF && reload_r != 16'hFFFF && !wrCount
		|=> cnt_r == 16'h0000)
		else $error("counter did not wrap to zero");
	AST_PRESCALE_ONE: assert property (run && ctrl_r.psSel == 3'h0 |-> tick)
		else $error("prescale of one did not tick every clock");
	AST_PRESCALE_MAX: assert property (run && ctrl_r.psSel == 3'h7 && tick && !wrCtrl
		|=> !tick [*8])
		else $error("prescale of 128 ticked too soon");
	AST_MIN_DELAY: assert property (state_r == gptm_pkg::ST_RUN && ctrl_r.psSel == 3'h0 &&
		cnt_r == 16'h0001 && reload_r == 16'h0001 |-> hit)
		else $error("shortest time-out was not one clock");
	AST_ONESHOT_STOP: assert property (hit && ctrl_r.mode == gptm_pkg::MODE_ONESHOT && !wrCtrl
		|=> !ctrl_r.en && !run ##1 !run)
		else $error("single-shot did not stop after time-out");
	AST_PULSE: assert property (hit && oneShotKind && !wrCtrl ##1 !wrCtrl
		|-> timerOut == !ctrl_r.inputOutputPolaritySelect
		##1 timerOut == ctrl_r.inputOutputPolaritySelect)
		else $error("single-shot output pulse not one clock wide");
	AST_TRIG_START: assert property (state_r == gptm_pkg::ST_ARMED && ctrl_r.en && trigEdge
		|=> run)
		else $error("armed timer did not start on trigger");
	AST_ARMED_HOLD: assert property (state_r == gptm_pkg::ST_ARMED && !wrCount
		|=> $stable(cnt_r))
		else $error("armed timer counted before trigger");
	AST_TRIG_IGNORED: assert property (run && ctrl_r.mode == gptm_pkg::MODE_TRIGGER &&
		ctrl_r.en && trigEdge && !hit |=> run)
		else $error("trigger during a run disturbed it");
	AST_IRQ: assert property (hit |=> timerIrq ##1 !timerIrq || $past(hit))
		else $error("time-out raised no interrupt");
	AST_TOGGLE: assert property (hit && run && ctrl_r.mode == gptm_pkg::MODE_CONT && !wrCtrl
		|=> timerOut != $past(timerOut) && run)
		else $error("continuous output did not toggle");
	AST_HOLD: assert property (!run && !wrCount |=> $stable(cnt_r))
		else $error("stopped counter changed");

	COV_ONESHOT: cover property (hit && ctrl_r.mode == gptm_pkg::MODE_ONESHOT);
	COV_TRIGGER: cover property (state_r == gptm_pkg::ST_ARMED && trigEdge ##[1:200] hit);
	COV_CONT_TWICE: cover property (hit && ctrl_r.mode == gptm_pkg::MODE_CONT ##[1:200] hit);
	COV_WRAP: cover property (tick && cnt_r == 16'hFFFF && reload_r != 16'hFFFF);

endmodule

// ---- logic/gptm_consts.svh ----
// register offsets, field positions, reset values and timing counts of the timer
`ifndef GPTM_CONSTS_SVH
`define GPTM_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define GPTM_OFF_CTRL     12'h000
`define GPTM_OFF_COUNT    12'h004
`define GPTM_OFF_RELOAD   12'h008
`define GPTM_OFF_STATUS   12'h00C

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define GPTM_CTRL_EN_BIT    0
`define GPTM_CTRL_MODE_LSB  1
`define GPTM_CTRL_PS_LSB    3
`define GPTM_CTRL_POL_BIT   6
`define GPTM_CTRL_AF_BIT    7
`define GPTM_CTRL_WIDTH     8

// ------------------------------------------------------------
// reset values and counter constants
// ------------------------------------------------------------
`define GPTM_RST_CTRL     8'h00
`define GPTM_RST_COUNT    16'h0001
`define GPTM_RST_RELOAD   16'h0000
`define GPTM_COUNT_START  16'h0001
`define GPTM_COUNT_MAX    16'hFFFF
`define GPTM_COUNT_WRAP   16'h0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GPTM_CLK_PERIOD_NS  10
`define GPTM_SYNC_STAGES    2

`endif

// ---- logic/gptm_pkg.sv ----
// types shared by the general-purpose timer files
package gptm_pkg;

	// ------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ONESHOT  = 2'b00,
		MODE_TRIGGER  = 2'b01,
		MODE_CONT     = 2'b10,
		MODE_RESERVED = 2'b11
	} gptm_mode_e;

	typedef enum logic [1:0] {
		ST_STOP  = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN   = 2'b10
	} gptm_state_e;

	// ------------------------------------------------------------
	// control register layout, msb first
	// ------------------------------------------------------------
	typedef struct packed {
		logic       outAf;
		logic       inputOutputPolaritySelect;
		logic [2:0] psSel;
		gptm_mode_e mode;
		logic       en;
	} gptm_ctrl_s;

endpackage

// ---- logic/gptm_prescaler.sv ----
// prescaler: divides the system clock by 2**psSel while the counter runs
`timescale 1ns/10ps
module gptm_prescaler (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [2:0] psSel,
	output logic            tick
);

	logic [6:0] psCnt_r;

	// ------------------------------------------------------------
	// divider mask: 2**sel - 1
	// ------------------------------------------------------------
	function automatic logic [6:0] psMask(input logic [2:0] sel);
		logic [7:0] full;
		full = 8'h01 << sel;
		return 7'(full - 8'h01);
	endfunction

	// a prescale of one ticks on every running clock
	assign tick = run && (psCnt_r == psMask(psSel));

	// restarts from zero each time the counter stops, so every run starts aligned
	always_ff @(posedge clk) begin
		if (!nrst) begin
			psCnt_r <= 7'h00;
		end else if (!run || tick) begin
			psCnt_r <= 7'h00;
		end else begin
			psCnt_r <= psCnt_r + 7'h01;
		end
	end

endmodule

// ---- verif/gptm_pin_partner.sv ----
// far-side pin model: external trigger source and timer output pad
`timescale 1ns/10ps
module gptm_pin_partner (
	input  wire logic clk,
	input  wire logic timerOut,
	input  wire logic timerOutAf,
	output logic      trigIn,
	output logic      padLevel
);
	// the pad has a pull-up, so a pin not given to the timer reads high
	assign padLevel = timerOutAf ? timerOut : 1'b1;

	initial begin
		trigIn = 1'b0;
	end

	// one level change right after an edge, held two clocks for the synchroniser
	task automatic drive(input logic v);
		@(posedge clk);
		trigIn <= v;
		repeat (2) @(posedge clk);
	endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the general-purpose timer
`timescale 1ns/10ps
`include "gptm_consts.svh"
module testbench;
	typedef struct {int lo; int hi; logic out;} gptm_irq_s;
	typedef struct {logic rd; logic [31:0] d; logic err;} gptm_bus_s;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic        trigIn, timerOut, timerOutAf, timerIrq, padLevel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] lfsr;
	int          cyc = 0;
	int          fail_count = 0;
	int          cmp_count = 0;
	gptm_irq_s   irqQ[$];
	gptm_bus_s   busQ[$];

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	gptm_timer u_gptm_timer (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigIn(trigIn), .timerOut(timerOut), .timerOutAf(timerOutAf),
		.timerIrq(timerIrq));
	gptm_pin_partner u_gptm_pin_partner (.clk(clk), .timerOut(timerOut),
		.timerOutAf(timerOutAf), .trigIn(trigIn), .padLevel(padLevel));

	// ------------------------------------------------------------
	// compares and closing
	// ------------------------------------------------------------
	task automatic chkVal(input logic [31:0] got, input logic [31:0] ex, input string m);
		cmp_count++;
		if (got !== ex) begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, ex);
		end
	endtask

	task automatic chkWin(input int t, input int lo, input int hi, input string m);
		cmp_count++;
		if (t < lo || t > hi) begin
			fail_count++;
			$display("FAIL %0t %s at %0d exp %0d..%0d", $time, m, t, lo, hi);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// edge counter; the ceiling is far above the several hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fail_count++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// monitor: each result takes the oldest note
	// ------------------------------------------------------------
	always @(posedge clk) begin
		gptm_bus_s b;
		gptm_irq_s e;
		if (psel && penable && pready === 1'b1) begin
			b = busQ.pop_front();
			if (b.rd) chkVal(prdata, b.d, "read data");
			chkVal(32'(pslverr), 32'(b.err), "slave error");
		end
		if (timerIrq === 1'b1) begin
			if (irqQ.size() == 0) chkVal(32'h1, 32'h0, "spurious irq");
			else begin
				e = irqQ.pop_front();
				chkWin(cyc, e.lo, e.hi, "irq time");
				chkVal(32'(padLevel), 32'(e.out), "pad level");
			end
		end
	end

	// ------------------------------------------------------------
	// bus tasks: request held until pready is seen high
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ex, input logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		busQ.push_back('{!wr, ex, er});
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0, ex, 1'b0);
	endtask

	task automatic rel();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic waitTo(input int n);
		while (cyc < n) @(posedge clk);
	endtask

	function automatic logic [31:0] cw(input logic af, input logic pol, input logic [2:0] ps,
		input logic [1:0] m, input logic en);
		return {24'h0, af, pol, ps, m, en};
	endfunction

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// single-shot run: disable, configure, load, enable, then expect the self-clear
	task automatic run(input logic [1:0] m, input logic [2:0] ps, input logic [15:0] s,
		input logic [15:0] r, input logic pol);
		logic [15:0] d;
		int          t;
		d = r - s;
		t = (int'(d) + 1) << ps;
		wr(`GPTM_OFF_CTRL, cw(1'b1, pol, ps, m, 1'b0));
		wr(`GPTM_OFF_COUNT, {16'h0, s});
		wr(`GPTM_OFF_RELOAD, {16'h0, r});
		wr(`GPTM_OFF_CTRL, cw(1'b1, pol, ps, m, 1'b1));
		irqQ.push_back('{cyc + t + 2, cyc + t + 2, !pol});
		rel();
		waitTo(cyc + t + 4);
		rd(`GPTM_OFF_CTRL, cw(1'b1, pol, ps, m, 1'b0));
		rd(`GPTM_OFF_COUNT, 32'h1);
		rel();
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int e;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lfsr = 16'h0047;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(`GPTM_OFF_CTRL, 32'h0);
		rd(`GPTM_OFF_COUNT, 32'h1);
		rd(`GPTM_OFF_RELOAD, 32'h0);
		rd(`GPTM_OFF_STATUS, 32'h0);
		apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
		rel();
		for (int i = 0; i < 4; i++) begin
			lfsr = nxt(lfsr);
			run(i[0] ? 2'b11 : 2'b00, {1'b0, lfsr[1:0]}, {12'h0, lfsr[7:4]} + 16'h1,
				{12'h0, lfsr[7:4]} + {12'h0, lfsr[11:8]} + 16'h1, lfsr[2]);
		end
		run(2'b00, 3'h7, 16'h0001, 16'h0002, 1'b0);
		run(2'b00, 3'h0, 16'hFFFE, 16'h0000, 1'b1);
		run(2'b00, 3'h0, 16'h0001, 16'h0001, 1'b0);
		// lasting level change: start low, raise the polarity bit once running
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b0, 3'h0, 2'b00, 1'b0));
		wr(`GPTM_OFF_COUNT, 32'h1);
		wr(`GPTM_OFF_RELOAD, 32'h6);
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b0, 3'h0, 2'b00, 1'b1));
		e = cyc;
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b1, 3'h0, 2'b00, 1'b1));
		irqQ.push_back('{e + 8, e + 8, 1'b0});
		rel();
		waitTo(e + 12);
		chkVal(32'(padLevel), 32'h1, "lasting level");
		// triggered: armed only, selected edge starts (rising, then falling), edges in the run are dropped
		for (int p = 0; p < 2; p++) begin
			wr(`GPTM_OFF_CTRL, cw(1'b1, p[0], 3'h0, 2'b01, 1'b0));
			wr(`GPTM_OFF_COUNT, 32'h1);
			wr(`GPTM_OFF_RELOAD, 32'h8);
			wr(`GPTM_OFF_CTRL, cw(1'b1, p[0], 3'h0, 2'b01, 1'b1));
			// one idle cycle so the setup edge latches the armed state
			rel();
			rd(`GPTM_OFF_STATUS, 32'h1);
			rel();
			repeat (10) @(posedge clk);
			u_gptm_pin_partner.drive(!p[0]);
			e = cyc - 2;
			irqQ.push_back('{e + 12, e + 13, !p[0]});
			u_gptm_pin_partner.drive(p[0]);
			u_gptm_pin_partner.drive(!p[0]);
			waitTo(e + 16);
			rd(`GPTM_OFF_STATUS, 32'h1);
			rel();
		end
		// continuous: first pass from the written start, later passes from one
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b1, 3'h1, 2'b10, 1'b0));
		wr(`GPTM_OFF_COUNT, 32'h3);
		wr(`GPTM_OFF_RELOAD, 32'h5);
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b1, 3'h1, 2'b10, 1'b1));
		e = cyc;
		rel();
		for (int k = 0; k < 3; k++)
			irqQ.push_back('{e + 8 + 10 * k, e + 8 + 10 * k, k[0]});
		waitTo(e + 29);
		wr(`GPTM_OFF_CTRL, cw(1'b1, 1'b1, 3'h1, 2'b10, 1'b0));
		// hold: one step lands at the disabling edge, then the count stays put
		wr(`GPTM_OFF_COUNT, 32'h0100);
		wr(`GPTM_OFF_RELOAD, 32'hFFFF);
		wr(`GPTM_OFF_CTRL, cw(1'b0, 1'b0, 3'h0, 2'b00, 1'b1));
		wr(`GPTM_OFF_CTRL, cw(1'b0, 1'b0, 3'h0, 2'b00, 1'b0));
		rel();
		repeat (20) @(posedge clk);
		rd(`GPTM_OFF_COUNT, 32'h0101);
		rd(`GPTM_OFF_STATUS, 32'h0);
		rel();
		repeat (4) @(posedge clk);
		chkVal(32'(irqQ.size()), 32'h0, "missing irq");
		summarize();
	end
endmodule
